/* rtl/blk_parser_pkg.sv */
// Function
// - error flag in byte 0 bit 7 set on any error, cleared on success
// - done flag in byte 0 bit 6 set once the block is finished
// - chain bit set: next block modifier and address locate the following block
// - scatter/gather bit selects link-list transfer instead of contiguous memory
// - completion code in byte 1: 00h success, other values error
// - byte 2 holds the last target status seen during this block
// - byte 3 bit 3 permits changing own bus identifier
// - byte 3 bit 1 exchanges 16-bit halves of every data longword
// - byte 3 bit 0 exchanges the two bytes of every data word
// - byte-swapped transfer with odd data address is refused with an error
// - byte 5 bit 4 holds data address fixed, otherwise it increments
// - target identifier taken from byte 5 bits 2-0
// - byte 6 bits 7-3 give list element count, 8 bytes each
// - completion interrupt at byte 6 level with byte 7 vector; level zero none
// - move exactly the byte count of bytes 9 to b; host matches command
// - byte e bits 5-0 are link-list or data address modifier
// - bytes 10-13 form data or link pointer, high part first
// - bytes 14-17 form next block pointer, followed only when chaining
// - command block taken from bytes 18h-23h and passed whole on
// - add-block request starts the block at the block address registers
// - finished block address loaded to registers and remove flag set
// - parameter blocks fetched and updated with 16-bit word transfers only
package blk_parser_pkg;
  localparam int BLK_WORDS = 18;
  localparam int BLK_BITS = 288;
  // register byte offsets
  localparam logic [7:0] OFS_BLK_ADDR = 8'h00;
  localparam logic [7:0] OFS_BLK_AM = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0c;
  // control write bits and status read bits
  localparam int CTRL_ADD = 0;
  localparam int CTRL_CLR_REMOVE = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_PEND = 1;
  localparam int STAT_REMOVE = 2;
  // block byte positions
  localparam int BYTE_FLAGS = 0;
  localparam int BYTE_CODE = 1;
  localparam int BYTE_STATUS = 2;
  localparam int BYTE_CMD = 3;
  localparam int BYTE_TGT = 5;
  localparam int BYTE_IRQ = 6;
  localparam int BYTE_VEC = 7;
  localparam int BYTE_CNT = 9;
  localparam int BYTE_DAM = 14;
  localparam int BYTE_NAM = 15;
  localparam int BYTE_DPTR = 16;
  localparam int BYTE_NPTR = 20;
  localparam int BYTE_CDB = 24;
  localparam int CDB_BYTES = 12;
  // field bit positions
  localparam int BIT_ERR = 7;
  localparam int BIT_DONE = 6;
  localparam int BIT_CHAIN = 5;
  localparam int BIT_SG = 4;
  localparam int BIT_IDCHG = 3;
  localparam int BIT_SWW = 1;
  localparam int BIT_SWB = 0;
  localparam int BIT_FIXED = 4;
  // completion codes
  localparam logic [7:0] CODE_OK = 8'h00;
  localparam logic [7:0] CODE_ODD_SWAP = 8'h01;
  // command block group codes and lengths
  localparam logic [2:0] GRP_SIX = 3'h0;
  localparam logic [2:0] GRP_TEN = 3'h1;
  localparam logic [3:0] CDB_LEN6 = 4'h6;
  localparam logic [3:0] CDB_LEN10 = 4'ha;
  localparam logic [3:0] CDB_LEN12 = 4'hc;
  // reset values
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [5:0] RST_AM = 6'h00;

  typedef struct packed {
    logic chain_link_on;
    logic scatter_gather_select;
    logic id_change_permit;
    logic word_half_exchange;
    logic byte_pair_exchange;
    logic fixed_address_transfer;
    logic [2:0] target_id_field;
    logic [4:0] list_element_count;
    logic [2:0] irq_level_field;
    logic [7:0] irq_vector;
    logic [23:0] byte_count;
    logic [5:0] data_space_code;
    logic [5:0] next_block_space_code;
    logic [31:0] data_ptr;
    logic [31:0] next_ptr;
  } blk_fields_t;
endpackage : blk_parser_pkg

/* rtl/blk_parser.sv */
`timescale 1ns/100ps
`default_nettype none
module blk_parser
  import blk_parser_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [5:0] mem_am_o,
  output logic [15:0] mem_wdata_o,
  input wire logic [15:0] mem_rdata_i,
  input wire logic mem_ack_i,
  output logic exec_start_o,
  output blk_fields_t fields_o,
  output logic [95:0] cdb_o,
  output logic [3:0] cdb_len_o,
  input wire logic exec_done_i,
  input wire logic [7:0] exec_code_i,
  input wire logic [7:0] exec_status_i,
  input wire logic xfer_step_i,
  input wire logic [2:0] xfer_size_i,
  output logic [31:0] xfer_addr_o,
  output logic [5:0] xfer_am_o,
  output logic [23:0] xfer_left_o,
  input wire logic [31:0] swap_in_i,
  input wire logic swap_valid_i,
  output logic [31:0] swap_out_o,
  output logic swap_valid_o,
  output logic irq_req_o,
  output logic [2:0] irq_level_o,
  output logic [7:0] irq_vector_o,
  input wire logic irq_ack_i
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FETCH = 3'b001,
    S_DECODE = 3'b010,
    S_EXEC = 3'b011,
    S_WB_STAT = 3'b100,
    S_WB_DONE = 3'b101,
    S_IRQ = 3'b110,
    S_RETIRE = 3'b111
  } state_t;

  // byte n of the flat block image, byte 0 in the top bits
  function automatic logic [7:0] get_b(input logic [BLK_BITS-1:0] f, input int n);
    get_b = f[BLK_BITS-1-8*n -: 8];
  endfunction : get_b

  // data lane exchange of halves and of bytes within each half
  function automatic logic [31:0] swap_fn(input logic [31:0] d, input logic ww, input logic bb);
    logic [31:0] t;
    t = ww ? {d[15:0], d[31:16]} : d;
    swap_fn = bb ? {t[23:16], t[31:24], t[7:0], t[15:8]} : t;
  endfunction : swap_fn

  state_t state_r;
  logic [15:0] words_r [0:BLK_WORDS-1];
  logic [BLK_BITS-1:0] flat;
  logic [7:0] blk_b [0:2*BLK_WORDS-1];
  logic [4:0] idx_r;
  logic [4:0] mem_idx;
  logic [31:0] cur_addr_r;
  logic [5:0] cur_am_r;
  logic [31:0] blk_addr_r;
  logic [5:0] blk_am_r;
  logic pend_r;
  logic remove_r;
  logic [7:0] code_r;
  logic [7:0] status_r;
  logic [31:0] xfer_addr_r;
  logic [23:0] xfer_left_r;
  blk_fields_t fields_r;
  blk_fields_t dec;
  logic [95:0] cdb_r;
  logic [95:0] dec_cdb;
  logic [3:0] cdb_len_r;
  logic [3:0] dec_len;
  logic [31:0] swap_out_r;
  logic swap_valid_r;
  logic irq_req_r;
  logic exec_start_r;
  logic apb_wr;
  logic apb_acc;
  logic mapped;
  logic busy;
  logic retire_fire;
  logic odd_swap;

  // apb decode, zero wait states
  assign apb_acc = psel_i & penable_i;
  assign apb_wr = apb_acc & pwrite_i;
  assign mapped = (paddr_i == OFS_BLK_ADDR) | (paddr_i == OFS_BLK_AM) |
                  (paddr_i == OFS_CTRL) | (paddr_i == OFS_RESULT);
  assign pready_o = 1'b1;
  assign pslverr_o = apb_acc & ~mapped;
  assign busy = (state_r != S_IDLE);
  assign retire_fire = (state_r == S_RETIRE) & ~remove_r;

  // register read mux
  always_comb begin
    prdata_o = 32'h0000_0000;
    if (paddr_i == OFS_BLK_ADDR) begin
      prdata_o = blk_addr_r;
    end else if (paddr_i == OFS_BLK_AM) begin
      prdata_o = {26'h000_0000, blk_am_r};
    end else if (paddr_i == OFS_CTRL) begin
      prdata_o[STAT_BUSY] = busy;
      prdata_o[STAT_PEND] = pend_r;
      prdata_o[STAT_REMOVE] = remove_r;
    end else if (paddr_i == OFS_RESULT) begin
      prdata_o = {16'h0000, status_r, code_r};
    end
  end

  // block address registers, host write or retire load
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      blk_addr_r <= RST_ADDR;
      blk_am_r <= RST_AM;
    end else if (ce_i) begin
      if (retire_fire) begin
        blk_addr_r <= cur_addr_r;
        blk_am_r <= cur_am_r;
      end else if (apb_wr && paddr_i == OFS_BLK_ADDR) begin
        blk_addr_r <= pwdata_i;
      end else if (apb_wr && paddr_i == OFS_BLK_AM) begin
        blk_am_r <= pwdata_i[5:0];
      end
    end
  end

  // add request pending flag
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_r <= 1'b0;
    end else if (ce_i) begin
      if (apb_wr && paddr_i == OFS_CTRL && pwdata_i[CTRL_ADD]) begin
        pend_r <= 1'b1;
      end else if (state_r == S_IDLE) begin
        pend_r <= 1'b0;
      end
    end
  end

  // remove flag, set wins over host clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      remove_r <= 1'b0;
    end else if (ce_i) begin
      if (retire_fire) begin
        remove_r <= 1'b1;
      end else if (apb_wr && paddr_i == OFS_CTRL && pwdata_i[CTRL_CLR_REMOVE]) begin
        remove_r <= 1'b0;
      end
    end
  end

  // flat image and byte view of the fetched words
  always_comb begin
    flat = '0;
    for (int i = 0; i < BLK_WORDS; i++) begin
      flat[BLK_BITS-1-16*i -: 16] = words_r[i];
      blk_b[2*i] = words_r[i][15:8];
      blk_b[2*i+1] = words_r[i][7:0];
    end
  end

  // field decode from the block image
  always_comb begin
    dec = '0;
    dec_cdb = '0;
    dec.chain_link_on = blk_b[BYTE_FLAGS][BIT_CHAIN];
    dec.scatter_gather_select = blk_b[BYTE_FLAGS][BIT_SG];
    dec.id_change_permit = blk_b[BYTE_CMD][BIT_IDCHG];
    dec.word_half_exchange = blk_b[BYTE_CMD][BIT_SWW];
    dec.byte_pair_exchange = blk_b[BYTE_CMD][BIT_SWB];
    dec.fixed_address_transfer = blk_b[BYTE_TGT][BIT_FIXED];
    dec.target_id_field = blk_b[BYTE_TGT][2:0];
    dec.list_element_count = blk_b[BYTE_IRQ][7:3];
    dec.irq_level_field = blk_b[BYTE_IRQ][2:0];
    dec.irq_vector = get_b(flat, BYTE_VEC);
    dec.byte_count = {get_b(flat, BYTE_CNT), get_b(flat, BYTE_CNT+1), get_b(flat, BYTE_CNT+2)};
    dec.data_space_code = blk_b[BYTE_DAM][5:0];
    dec.next_block_space_code = blk_b[BYTE_NAM][5:0];
    dec.data_ptr = {get_b(flat, BYTE_DPTR), get_b(flat, BYTE_DPTR+1),
                    get_b(flat, BYTE_DPTR+2), get_b(flat, BYTE_DPTR+3)};
    dec.next_ptr = {get_b(flat, BYTE_NPTR), get_b(flat, BYTE_NPTR+1),
                    get_b(flat, BYTE_NPTR+2), get_b(flat, BYTE_NPTR+3)};
    for (int i = 0; i < CDB_BYTES; i++) begin
      dec_cdb[95-8*i -: 8] = get_b(flat, BYTE_CDB+i);
    end
  end

  // command block length from its group code
  always_comb begin
    if (dec_cdb[95:93] == GRP_SIX) begin
      dec_len = CDB_LEN6;
    end else if (dec_cdb[95:93] == GRP_TEN) begin
      dec_len = CDB_LEN10;
    end else begin
      dec_len = CDB_LEN12;
    end
  end

  assign odd_swap = dec.byte_pair_exchange & dec.data_ptr[0];

  // control sequence
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= S_IDLE;
      idx_r <= 5'h00;
      cur_addr_r <= RST_ADDR;
      cur_am_r <= RST_AM;
      code_r <= CODE_OK;
      status_r <= 8'h00;
    end else if (ce_i) begin
      unique case (state_r)
        S_IDLE: begin
          if (pend_r) begin
            cur_addr_r <= blk_addr_r;
            cur_am_r <= blk_am_r;
            idx_r <= 5'h00;
            state_r <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (mem_ack_i) begin
            idx_r <= idx_r + 5'h01;
            if (idx_r == 5'(BLK_WORDS-1)) begin
              state_r <= S_DECODE;
            end
          end
        end
        S_DECODE: begin
          if (odd_swap) begin
            code_r <= CODE_ODD_SWAP;
            status_r <= 8'h00;
            state_r <= S_WB_STAT;
          end else begin
            state_r <= S_EXEC;
          end
        end
        S_EXEC: begin
          if (exec_done_i) begin
            code_r <= exec_code_i;
            status_r <= exec_status_i;
            state_r <= S_WB_STAT;
          end
        end
        S_WB_STAT: begin
          if (mem_ack_i) begin
            state_r <= S_WB_DONE;
          end
        end
        S_WB_DONE: begin
          if (mem_ack_i) begin
            state_r <= (fields_r.irq_level_field != 3'h0) ? S_IRQ : S_RETIRE;
          end
        end
        S_IRQ: begin
          if (irq_ack_i) begin
            state_r <= S_RETIRE;
          end
        end
        S_RETIRE: begin
          if (!remove_r) begin
            if (fields_r.chain_link_on) begin
              cur_addr_r <= fields_r.next_ptr;
              cur_am_r <= fields_r.next_block_space_code;
              idx_r <= 5'h00;
              state_r <= S_FETCH;
            end else begin
              state_r <= S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // fetched word storage
  always_ff @(posedge clk_i) begin
    if (ce_i && state_r == S_FETCH && mem_ack_i) begin
      words_r[idx_r] <= mem_rdata_i;
    end
  end

  // decoded fields and start pulse
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fields_r <= '0;
      cdb_r <= '0;
      cdb_len_r <= CDB_LEN6;
      exec_start_r <= 1'b0;
    end else if (ce_i) begin
      exec_start_r <= (state_r == S_DECODE) & ~odd_swap;
      if (state_r == S_DECODE) begin
        fields_r <= dec;
        cdb_r <= dec_cdb;
        cdb_len_r <= dec_len;
      end
    end
  end

  // transfer address and remaining count
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xfer_addr_r <= RST_ADDR;
      xfer_left_r <= 24'h00_0000;
    end else if (ce_i) begin
      if (state_r == S_DECODE) begin
        xfer_addr_r <= dec.data_ptr;
        xfer_left_r <= dec.byte_count;
      end else if (state_r == S_EXEC && xfer_step_i) begin
        if (!fields_r.fixed_address_transfer) begin
          xfer_addr_r <= xfer_addr_r + {29'h0000_0000, xfer_size_i};
        end
        xfer_left_r <= xfer_left_r - {21'h00_0000, xfer_size_i};
      end
    end
  end

  // data lane swap stage
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      swap_out_r <= 32'h0000_0000;
      swap_valid_r <= 1'b0;
    end else if (ce_i) begin
      swap_valid_r <= swap_valid_i;
      if (swap_valid_i) begin
        swap_out_r <= swap_fn(swap_in_i, fields_r.word_half_exchange,
                              fields_r.byte_pair_exchange);
      end
    end
  end

  // completion interrupt request
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_req_r <= 1'b0;
    end else if (ce_i) begin
      irq_req_r <= (state_r == S_WB_DONE && mem_ack_i && fields_r.irq_level_field != 3'h0) |
                   (irq_req_r & ~irq_ack_i);
    end
  end

  // memory word port, block accesses only
  always_comb begin
    mem_idx = idx_r;
    if (state_r == S_WB_STAT) begin
      mem_idx = 5'h01;
    end else if (state_r == S_WB_DONE) begin
      mem_idx = 5'h00;
    end
  end

  assign mem_req_o = (state_r == S_FETCH) | (state_r == S_WB_STAT) | (state_r == S_WB_DONE);
  assign mem_we_o = (state_r == S_WB_STAT) | (state_r == S_WB_DONE);
  assign mem_addr_o = cur_addr_r + {26'h000_0000, mem_idx, 1'b0};
  assign mem_am_o = cur_am_r;

  // write-back words: status word then flags with code
  always_comb begin
    mem_wdata_o = 16'h0000;
    if (state_r == S_WB_STAT) begin
      mem_wdata_o = {status_r, get_b(flat, BYTE_CMD)};
    end else if (state_r == S_WB_DONE) begin
      mem_wdata_o = {(code_r != CODE_OK), 1'b1, blk_b[BYTE_FLAGS][5:0], code_r};
    end
  end

  assign exec_start_o = exec_start_r;
  assign fields_o = fields_r;
  assign cdb_o = cdb_r;
  assign cdb_len_o = cdb_len_r;
  assign xfer_addr_o = xfer_addr_r;
  assign xfer_left_o = xfer_left_r;
  assign xfer_am_o = fields_r.data_space_code;
  assign swap_out_o = swap_out_r;
  assign swap_valid_o = swap_valid_r;
  assign irq_req_o = irq_req_r;
  assign irq_level_o = fields_r.irq_level_field;
  assign irq_vector_o = fields_r.irq_vector;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_DONE_BIT: assert property ((state_r == S_WB_DONE) |-> mem_wdata_o[8+BIT_DONE])
    else $error("done flag missing in write-back");
  AST_ERR_FLAG: assert property ((state_r == S_WB_DONE) |->
      mem_wdata_o[8+BIT_ERR] == (mem_wdata_o[7:0] != CODE_OK))
    else $error("error flag disagrees with code");
  AST_CODE_BYTE: assert property ((state_r == S_WB_DONE) |-> mem_wdata_o[7:0] == code_r)
    else $error("completion code not written");
  AST_STAT_FIRST: assert property ((state_r == S_WB_DONE) && ($past(state_r) != S_WB_DONE)
      |-> $past(state_r) == S_WB_STAT)
    else $error("done written before results");
  AST_STAT_BYTE: assert property ((state_r == S_WB_STAT) |-> mem_wdata_o[15:8] == status_r)
    else $error("status byte wrong");
  AST_ODD_SWAP: assert property (ce_i && state_r == S_DECODE && odd_swap
      |=> state_r == S_WB_STAT && code_r == CODE_ODD_SWAP && !exec_start_o)
    else $error("odd swapped transfer not refused");
  AST_FIXED: assert property (ce_i && state_r == S_EXEC && xfer_step_i
      && fields_r.fixed_address_transfer |=> $stable(xfer_addr_o))
    else $error("fixed address moved");
  AST_COUNT: assert property (ce_i && state_r == S_EXEC && xfer_step_i
      |=> xfer_left_o == $past(xfer_left_o) - {21'h00_0000, $past(xfer_size_i)})
    else $error("byte count not reduced by step");
  AST_IRQ_LEVEL: assert property (irq_req_o |-> irq_level_o != 3'h0)
    else $error("interrupt at level zero");
  AST_CHAIN: assert property (ce_i && retire_fire && fields_r.chain_link_on
      |=> state_r == S_FETCH && cur_addr_r == $past(fields_r.next_ptr))
    else $error("chain not followed");
  AST_REMOVE: assert property (ce_i && retire_fire
      |=> remove_r && blk_addr_r == $past(cur_addr_r))
    else $error("remove flag or address not posted");
  AST_SWAP: assert property (ce_i && swap_valid_i |=> swap_valid_o && swap_out_o ==
      swap_fn($past(swap_in_i), fields_r.word_half_exchange, fields_r.byte_pair_exchange))
    else $error("data swap wrong");

  COV_CHAIN: cover property (retire_fire && fields_r.chain_link_on);
  COV_ODD: cover property (state_r == S_DECODE && odd_swap);
  COV_IRQ: cover property (irq_req_o && irq_ack_i);
endmodule : blk_parser
`default_nettype wire

/* test/blk_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module blk_mem_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic slow_i,
  output logic [15:0] rdata_o,
  output logic ack_o
);
  logic [15:0] words [0:63];
  logic [1:0] wait_r;

  // host memory, one 16-bit word per ack, optional two-cycle stall
  // word transfers only
  // plain always: the bench preloads the words at time zero
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_o <= 1'b0;
      wait_r <= 2'h0;
      rdata_o <= 16'h0000;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o; // released bus shows no stale word
    end else if (req_i) begin
      if (slow_i && wait_r != 2'h2) begin
        wait_r <= wait_r + 2'h1;
      end else begin
        ack_o <= 1'b1;
        wait_r <= 2'h0;
        if (we_i) begin
          words[addr_i[6:1]] <= wdata_i;
        end else begin
          rdata_o <= words[addr_i[6:1]];
        end
      end
    end
  end
endmodule : blk_mem_model
`default_nettype wire

/* test/tb_blk_parser.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_blk_parser;
  import blk_parser_pkg::*;
  logic clk_i = 0, nrst_i = 0, ce_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, slow = 0;
  logic exec_done_i = 0, xfer_step_i = 0, swap_valid_i = 0, irq_ack_i = 0, err, irq_q = 0;
  logic [7:0] paddr_i = 0, exec_code_i = 0, exec_status_i = 0, irq_vector_o;
  logic [31:0] pwdata_i = 0, swap_in_i = 0, prdata_o, mem_addr_o, xfer_addr_o, swap_out_o, rd;
  logic [2:0] xfer_size_i = 0, irq_level_o;
  logic [15:0] mem_rdata_i, mem_wdata_o;
  logic [5:0] mem_am_o, xfer_am_o;
  logic [23:0] xfer_left_o;
  logic [95:0] cdb_o;
  logic [3:0] cdb_len_o;
  logic pready_o, pslverr_o, mem_req_o, mem_we_o, mem_ack_i, exec_start_o, swap_valid_o, irq_req_o;
  blk_fields_t fields_o, ef;
  logic [5:0] wr_q [$];
  int failures = 0, comparisons = 0, cyc = 0, rd_cnt = 0, starts = 0, irqs = 0, i;
  // first block: code 00h, chained with a valid next modifier
  logic [15:0] blk_a [18] = '{16'h2f00, 16'h000b, 16'h0005, 16'h1a5a, 16'h0000, 16'h0100,
    16'h0000, 16'h3d39, 16'h0000, 16'h1000, 16'h0000, 16'h0030, 16'h2800, 16'h0000,
    16'h0010, 16'h0000, 16'h0100, 16'h0000};

  blk_parser dut (.clk_i, .nrst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_am_o,
    .mem_wdata_o, .mem_rdata_i, .mem_ack_i, .exec_start_o, .fields_o, .cdb_o, .cdb_len_o,
    .exec_done_i, .exec_code_i, .exec_status_i, .xfer_step_i, .xfer_size_i, .xfer_addr_o,
    .xfer_am_o, .xfer_left_o, .swap_in_i, .swap_valid_i, .swap_out_o, .swap_valid_o,
    .irq_req_o, .irq_level_o, .irq_vector_o, .irq_ack_i);
  blk_mem_model mem (.clk_i, .nrst_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .slow_i(slow), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));

  // clock, 50 ns period
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // traffic monitor and hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (mem_req_o === 1'b1 && mem_ack_i === 1'b1) begin
      if (mem_we_o === 1'b1) wr_q.push_back(mem_addr_o[6:1]);
      else rd_cnt++;
    end
    if (exec_start_o === 1'b1) starts++;
    if (irq_req_o === 1'b1 && !irq_q) irqs++;
    irq_q <= (irq_req_o === 1'b1);
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask : tick

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic results;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // main sequence: chained pair (second refused), then a fixed-address block
  initial begin
    for (i = 0; i < 64; i++) mem.words[i] = 16'h0000;
    for (i = 0; i < 18; i++) mem.words[i] = blk_a[i];
    // second block: byte swap at an odd data address
    mem.words[24] = 16'h0f00;
    mem.words[25] = 16'h0001;
    mem.words[31] = 16'h3d00;
    mem.words[33] = 16'h1001;
    // third block: fixed address, level zero, 6-byte command
    mem.words[44] = 16'h0f00;
    mem.words[46] = 16'h0010;
    mem.words[49] = 16'h0010;
    mem.words[53] = 16'h2000;
    mem.words[56] = 16'h0800;
    ef = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 3'd5, 5'd3, 3'd2, 8'h5a, 24'h000100, 6'h3d,
      6'h39, 32'h0000_1000, 32'h0000_0030};
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    apb(1'b0, OFS_BLK_ADDR, 32'h0);
    chk(rd, RST_ADDR);
    apb(1'b1, 8'h10, 32'h5);
    chk(err, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1'b1, OFS_BLK_ADDR, 32'h0);
    apb(1'b1, OFS_BLK_AM, 32'h3d);
    apb(1'b1, OFS_CTRL, 32'h1);
    while (exec_start_o !== 1'b1) tick();
    chk(fields_o, ef);
    chk({cdb_len_o, cdb_o}, {CDB_LEN10, 96'h2800_0000_0010_0000_0100_0000});
    chk({xfer_am_o, xfer_addr_o, xfer_left_o}, {6'h3d, 32'h1000, 24'h100});
    // swap stage, then two 4-byte steps
    @(posedge clk_i);
    swap_in_i <= 32'h1122_3344;
    swap_valid_i <= 1'b1;
    @(posedge clk_i);
    swap_valid_i <= 1'b0;
    xfer_step_i <= 1'b1;
    xfer_size_i <= 3'd4;
    #1;
    chk({swap_valid_o, swap_out_o}, {1'b1, 32'h4433_2211});
    repeat (2) @(posedge clk_i);
    xfer_step_i <= 1'b0;
    exec_done_i <= 1'b1;
    exec_status_i <= 8'h04;
    #1;
    chk({xfer_addr_o, xfer_left_o}, {32'h1008, 24'h0000f8});
    @(posedge clk_i);
    exec_done_i <= 1'b0;
    while (irq_req_o !== 1'b1) tick();
    chk({mem.words[0], mem.words[1]}, {16'h6f00, 16'h040b});
    chk({irq_level_o, irq_vector_o}, {3'd2, 8'h5a});
    @(posedge clk_i);
    slow <= 1'b1;
    irq_ack_i <= 1'b1;
    @(posedge clk_i);
    irq_ack_i <= 1'b0;
    #1;
    chk(irq_req_o, 1'b0);
    do apb(1'b0, OFS_CTRL, 32'h0); while (rd[STAT_REMOVE] !== 1'b1);
    apb(1'b0, OFS_BLK_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_BLK_AM, 32'h0);
    chk(rd, 32'h3d);
    while (mem.words[24][14] !== 1'b1) tick();
    chk({mem.words[24], mem.words[25]}, {16'hcf01, 16'h0001});
    apb(1'b1, OFS_CTRL, 32'h2);
    do apb(1'b0, OFS_BLK_ADDR, 32'h0); while (rd !== 32'h30);
    apb(1'b0, OFS_BLK_AM, 32'h0);
    chk(rd, 32'h39);
    apb(1'b0, OFS_RESULT, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd[STAT_REMOVE], 1'b1);
    // third block: clear remove and add in one write
    apb(1'b1, OFS_BLK_ADDR, 32'h58);
    apb(1'b1, OFS_CTRL, 32'h3);
    while (exec_start_o !== 1'b1) tick();
    chk(fields_o.fixed_address_transfer, 1'b1);
    chk({cdb_len_o, xfer_addr_o, xfer_left_o}, {CDB_LEN6, 32'h2000, 24'h10});
    // clock enable low freezes the step
    @(posedge clk_i);
    ce_i <= 1'b0;
    xfer_step_i <= 1'b1;
    xfer_size_i <= 3'd2;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    #1;
    chk({xfer_addr_o, xfer_left_o, exec_start_o}, {32'h2000, 24'h10, 1'b0});
    @(posedge clk_i);
    xfer_step_i <= 1'b0;
    exec_done_i <= 1'b1;
    exec_code_i <= 8'h02;
    exec_status_i <= 8'h02;
    #1;
    chk({xfer_addr_o, xfer_left_o}, {32'h2000, 24'h00000e});
    @(posedge clk_i);
    exec_done_i <= 1'b0;
    while (mem.words[44][14] !== 1'b1) tick();
    chk({mem.words[44], mem.words[45]}, {16'hcf02, 16'h0200});
    do apb(1'b0, OFS_CTRL, 32'h0); while (rd[STAT_REMOVE] !== 1'b1);
    chk({irq_req_o, rd[2:0]}, {1'b0, 3'b100});
    apb(1'b0, OFS_BLK_ADDR, 32'h0);
    chk(rd, 32'h58);
    apb(1'b0, OFS_RESULT, 32'h0);
    chk(rd, 32'h0202);
    chk({wr_q[0], wr_q[1], wr_q[2], wr_q[3]}, {6'd1, 6'd0, 6'd25, 6'd24});
    chk({wr_q[4], wr_q[5]}, {6'd45, 6'd44});
    chk({rd_cnt, starts, irqs}, {32'd54, 32'd2, 32'd1});
    results();
  end
endmodule : tb_blk_parser
`default_nettype wire
